/* trpo_pkg.sv */
// shared constants and types for the tft rgb panel output block
package trpo_pkg;
  // =========================================================
  // pixel formats carried with each stored word
  typedef enum logic [1:0] {
    FMT_RGB888,
    FMT_RGB565,
    FMT_RGB332,
    FMT_INDEX
  } trpo_fmt_t;

  // =========================================================
  // output width select codes
  localparam logic [1:0] WSEL_24 = 2'h0;
  localparam logic [1:0] WSEL_18 = 2'h1;
  localparam logic [1:0] WSEL_16 = 2'h2;

  // =========================================================
  // widths
  localparam int PIX_W = 24;
  localparam int WORD_W = PIX_W + 2;
  localparam int DIV_W = 16;
  localparam int PAL_AW = 9;
  localparam int PAL_W = 12;
  localparam int FIFO_DEPTH_DEF = 8;

  // =========================================================
  // panel lines left without a colour bit
  localparam logic [23:0] LOW2_MASK = 24'h030303;
  localparam logic [23:0] LOW3_MASK = 24'h070307;

  // =========================================================
  // default scan timing, in pixel clocks and lines
  localparam logic [11:0] H_ACTIVE_DEF = 12'h320;
  localparam logic [11:0] H_FP_DEF = 12'h028;
  localparam logic [11:0] H_SYNC_DEF = 12'h030;
  localparam logic [11:0] H_BP_DEF = 12'h028;
  localparam logic [11:0] V_ACTIVE_DEF = 12'h1e0;
  localparam logic [11:0] V_FP_DEF = 12'h00d;
  localparam logic [11:0] V_SYNC_DEF = 12'h003;
  localparam logic [11:0] V_BP_DEF = 12'h01d;
endpackage

/* trpo_stream_if.sv */
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface trpo_stream_if #(
  parameter int W = 26
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* trpo_fifo.sv */
// show-ahead fifo buffering stored pixels ahead of the scan logic
`timescale 1ns/1ps
`default_nettype none
module trpo_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  trpo_stream_if.snk wr_if,
  trpo_stream_if.src rd_if
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic not_full;
    logic has_data;
  } trpo_fifo_state_t;

  trpo_fifo_state_t s_q;
  trpo_fifo_state_t s_d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("trpo_fifo: DEPTH must be a power of two, at least 2");
  end

  // flags are registered so ready and valid leave straight from flops
  assign wr_if.ready = s_q.not_full;
  assign rd_if.valid = s_q.has_data;
  assign rd_if.data = s_q.mem[s_q.rd];

  always_comb begin
    s_d = s_q;
    push = wr_if.valid && s_q.not_full;
    pop = rd_if.ready && s_q.has_data;
    if (push) begin
      s_d.mem[s_q.wr] = wr_if.data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: s_d.cnt = s_q.cnt + 1'b1;
      2'b01: s_d.cnt = s_q.cnt - 1'b1;
      default: s_d.cnt = s_q.cnt;
    endcase
    s_d.not_full = (s_d.cnt != FULL_CNT);
    s_d.has_data = (s_d.cnt != '0);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      s_q.not_full <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // trpo_fifo
`default_nettype wire

/* trpo_panel_output.sv */
// panel output: format expansion, palette, scan clock, sync and bus mapping
`timescale 1ns/1ps
`default_nettype none
// =========================================================
module trpo_panel_output
  import trpo_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [11:0] H_ACTIVE = H_ACTIVE_DEF,
  parameter logic [11:0] H_FP = H_FP_DEF,
  parameter logic [11:0] H_SYNC = H_SYNC_DEF,
  parameter logic [11:0] H_BP = H_BP_DEF,
  parameter logic [11:0] V_ACTIVE = V_ACTIVE_DEF,
  parameter logic [11:0] V_FP = V_FP_DEF,
  parameter logic [11:0] V_SYNC = V_SYNC_DEF,
  parameter logic [11:0] V_BP = V_BP_DEF
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic pix_valid_in,
  input wire logic [1:0] pix_fmt_in,
  input wire logic [PIX_W-1:0] pix_data_in,
  output logic pix_ready_out,
  input wire logic [1:0] width_sel_in,
  input wire logic [7:0] pclk_div_lo_in,
  input wire logic [7:0] pclk_div_hi_in,
  input wire logic pal_wr_in,
  input wire logic [PAL_AW-1:0] pal_addr_in,
  input wire logic [PAL_W-1:0] pal_wdata_in,
  output logic pclk_out,
  output logic hsync_n_out,
  output logic vsync_n_out,
  output logic de_out,
  output logic [PIX_W-1:0] panel_data_bus_out,
  output logic underrun_out
);
  // =========================================================
  // derived timing
  localparam logic [11:0] HS_START = H_ACTIVE + H_FP;
  localparam logic [11:0] HS_END = HS_START + H_SYNC;
  localparam logic [11:0] H_LAST = HS_END + H_BP - 12'h001;
  localparam logic [11:0] VS_START = V_ACTIVE + V_FP;
  localparam logic [11:0] VS_END = VS_START + V_SYNC;
  localparam logic [11:0] V_LAST = VS_END + V_BP - 12'h001;
  localparam int PAL_DEPTH = 2 ** (PAL_AW - 1);

  if (int'(H_ACTIVE) + int'(H_FP) + int'(H_SYNC) + int'(H_BP) > 4096 ||
      int'(V_ACTIVE) + int'(V_FP) + int'(V_SYNC) + int'(V_BP) > 4096 ||
      H_ACTIVE == 12'h000 || V_ACTIVE == 12'h000 ||
      H_SYNC == 12'h000 || V_SYNC == 12'h000) begin : g_bad_timing
    $error("trpo_panel_output: scan timing does not fit the counters");
  end

  // =========================================================
  // state
  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic pclk;
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic stg_de;
    logic stg_hs_n;
    logic stg_vs_n;
    trpo_fmt_t stg_fmt;
    logic [PIX_W-1:0] stg_data;
    logic de;
    logic hs_n;
    logic vs_n;
    logic [PIX_W-1:0] bus;
    logic under;
    logic [DIV_W-1:0] gap;
    logic seen;
    logic [DIV_W-1:0] div_prev;
  } trpo_state_t;

  trpo_state_t s_q;
  trpo_state_t s_d;
  logic [DIV_W-1:0] div_w;
  logic tick;
  logic adv;
  logic active;
  logic h_end;
  logic [PIX_W-1:0] shown;
  logic [PAL_W-1:0] pal_mem [PAL_DEPTH];
  logic [PAL_W-1:0] pal_q;

  trpo_stream_if #(.W(WORD_W)) in_if ();
  trpo_stream_if #(.W(WORD_W)) rd_if ();

  // =========================================================
  // input buffer
  assign in_if.valid = pix_valid_in;
  assign in_if.data = {pix_fmt_in, pix_data_in};
  assign pix_ready_out = in_if.ready;

  trpo_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_if(in_if.snk),
    .rd_if(rd_if.src)
  );

  // =========================================================
  // format expansion; short fields repeat their top bits to fill 8
  function automatic logic [PIX_W-1:0] expand_rgb(
    input trpo_fmt_t fmt,
    input logic [PIX_W-1:0] d,
    input logic [PAL_W-1:0] p
  );
    case (fmt)
      FMT_RGB565: expand_rgb = {d[15:11], d[15:13], d[10:5], d[10:9],
                                d[4:0], d[4:2]};
      FMT_RGB332: expand_rgb = {d[7:5], d[7:5], d[7:6], d[4:2], d[4:2],
                                d[4:3], {4{d[1:0]}}};
      FMT_INDEX: expand_rgb = {p[11:8], p[11:8], p[7:4], p[7:4],
                               p[3:0], p[3:0]};
      default: expand_rgb = d;
    endcase
  endfunction

  // rgb already sits at its 24-bit line positions, so narrower modes
  // only need the lines below each colour's top bits forced low
  function automatic logic [PIX_W-1:0] map_bus(
    input logic [1:0] wsel,
    input logic [PIX_W-1:0] rgb
  );
    logic [PIX_W-1:0] c;
    c = NARROW_BUS ? (rgb & ~LOW2_MASK) : rgb;
    case (wsel)
      WSEL_16: map_bus = c & ~LOW3_MASK;
      WSEL_18: map_bus = c & ~LOW2_MASK;
      default: map_bus = c;
    endcase
  endfunction

  // =========================================================
  // palette; index is the byte address over two
  always_ff @(posedge clk_in) begin
    if (pal_wr_in) begin
      pal_mem[pal_addr_in[PAL_AW-1:1]] <= pal_wdata_in;
    end
    if (rd_if.ready) begin
      pal_q <= pal_mem[rd_if.data[PAL_AW-2:0]];
    end
  end

  // =========================================================
  // scan engine
  assign div_w = {pclk_div_hi_in, pclk_div_lo_in};

  always_comb begin
    s_d = s_q;
    // >= so a divisor lowered mid-count does not wrap the counter
    tick = (s_q.div_cnt >= div_w);
    adv = tick && s_q.pclk;
    h_end = (s_q.hcnt == H_LAST);
    active = (s_q.hcnt < H_ACTIVE) && (s_q.vcnt < V_ACTIVE);
    rd_if.ready = adv && active && rd_if.valid;
    shown = expand_rgb(s_q.stg_fmt, s_q.stg_data, pal_q);
    s_d.div_cnt = tick ? '0 : s_q.div_cnt + 1'b1;
    if (tick) begin
      s_d.pclk = ~s_q.pclk;
    end
    // data moves on the falling panel clock, panel samples on rising
    if (adv) begin
      s_d.hcnt = h_end ? 12'h000 : s_q.hcnt + 12'h001;
      if (h_end) begin
        s_d.vcnt = (s_q.vcnt == V_LAST) ? 12'h000 : s_q.vcnt + 12'h001;
      end
      // an empty buffer inside the active area shows black
      s_d.stg_de = active;
      s_d.stg_fmt = rd_if.valid ? trpo_fmt_t'(rd_if.data[WORD_W-1:PIX_W])
                                : FMT_RGB888;
      s_d.stg_data = rd_if.valid ? rd_if.data[PIX_W-1:0] : '0;
      s_d.stg_hs_n = !(s_q.hcnt >= HS_START && s_q.hcnt < HS_END);
      s_d.stg_vs_n = !(s_q.vcnt >= VS_START && s_q.vcnt < VS_END);
      s_d.under = active && !rd_if.valid;
      s_d.de = s_q.stg_de;
      s_d.hs_n = s_q.stg_hs_n;
      s_d.vs_n = s_q.stg_vs_n;
      s_d.bus = s_q.stg_de ? map_bus(width_sel_in, shown) : '0;
    end
    // helper for the clock period check
    s_d.div_prev = div_w;
    s_d.gap = (s_d.pclk != s_q.pclk) ? '0 : s_q.gap + 1'b1;
    if (div_w != s_q.div_prev) begin
      s_d.seen = 1'b0;
    end else if (tick) begin
      s_d.seen = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      s_q.stg_hs_n <= 1'b1;
      s_q.stg_vs_n <= 1'b1;
      s_q.hs_n <= 1'b1;
      s_q.vs_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // =========================================================
  // outputs
  assign pclk_out = s_q.pclk;
  assign hsync_n_out = s_q.hs_n;
  assign vsync_n_out = s_q.vs_n;
  assign de_out = s_q.de;
  assign panel_data_bus_out = s_q.bus;
  assign underrun_out = s_q.under;

  // =========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_adv_shown;
    adv && s_q.stg_de;
  endsequence

  sequence s_adv_active;
    adv && active;
  endsequence

  property p_map24;
    s_adv_shown ##0 (width_sel_in == WSEL_24 && !NARROW_BUS)
      |=> panel_data_bus_out == $past(shown) && de_out;
  endproperty
  a_map24: assert property (p_map24)
    else $error("24-bit lines do not carry the pixel");

  property p_map18;
    s_adv_shown ##0 (width_sel_in == WSEL_18) |=>
      panel_data_bus_out[23:18] == $past(shown[23:18]) &&
      panel_data_bus_out[15:10] == $past(shown[15:10]) &&
      panel_data_bus_out[7:2] == $past(shown[7:2]);
  endproperty
  a_map18: assert property (p_map18)
    else $error("18-bit lines misplaced");

  property p_map16;
    s_adv_shown ##0 (width_sel_in == WSEL_16) |=>
      panel_data_bus_out[23:19] == $past(shown[23:19]) &&
      panel_data_bus_out[15:10] == $past(shown[15:10]) &&
      panel_data_bus_out[7:3] == $past(shown[7:3]);
  endproperty
  a_map16: assert property (p_map16)
    else $error("16-bit lines misplaced");

  property p_idle_low;
    s_adv_shown ##0 (width_sel_in == WSEL_16)
      |=> (panel_data_bus_out & LOW3_MASK) == '0;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("unused 16-bit lines not low");

  property p_narrow;
    NARROW_BUS |-> (panel_data_bus_out & LOW2_MASK) == '0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow variant drives low colour bits");

  property p_pclk;
    $changed(pclk_out) && s_q.seen |-> $past(s_q.gap) == $past(div_w);
  endproperty
  a_pclk: assert property (p_pclk)
    else $error("scan clock half period differs from divisor");

  property p_sync_blank;
    de_out |-> hsync_n_out && vsync_n_out;
  endproperty
  a_sync_blank: assert property (p_sync_blank)
    else $error("sync active during data enable");

  property p_pal;
    s_adv_shown ##0 (s_q.stg_fmt == FMT_INDEX) |->
      shown[23:20] == pal_q[11:8] && shown[15:12] == pal_q[7:4] &&
      shown[7:4] == pal_q[3:0];
  endproperty
  a_pal: assert property (p_pal)
    else $error("palette nibbles misplaced");

  property p_565;
    s_adv_shown ##0 (s_q.stg_fmt == FMT_RGB565) |->
      shown[23:19] == s_q.stg_data[15:11] &&
      shown[15:10] == s_q.stg_data[10:5] &&
      shown[7:3] == s_q.stg_data[4:0];
  endproperty
  a_565: assert property (p_565)
    else $error("16bpp expansion wrong");

  property p_under;
    s_adv_active ##0 !rd_if.valid |=> underrun_out ##1 !de_out[*1]
      or underrun_out;
  endproperty
  a_under: assert property (p_under)
    else $error("empty buffer in active area not flagged");
endmodule // trpo_panel_output
`default_nettype wire

/* trpo_panel_model.sv */
// behavioural panel source driver that captures what the block scans out
`timescale 1ns/1ps
`default_nettype none
module trpo_panel_model (
  input wire logic pclk_in,
  input wire logic hsync_n_in,
  input wire logic vsync_n_in,
  input wire logic de_in,
  input wire logic [23:0] data_in,
  output var logic [23:0] last_px_out,
  output var int px_cnt_out,
  output var int blank_bad_out,
  output var int frame_px_out,
  output var int frame_lines_out,
  output var int frames_out
);
  int run_px;
  int run_lines;
  logic hs_q;
  logic vs_q;
  initial begin
    last_px_out = 24'h000000;
    px_cnt_out = 0;
    blank_bad_out = 0;
    frame_px_out = 0;
    frame_lines_out = 0;
    frames_out = 0;
    run_px = 0;
    run_lines = 0;
    hs_q = 1'b1;
    vs_q = 1'b1;
  end
  // =========================================================
  // sample on the rising scan clock, mid-way through a stable pixel
  always @(posedge pclk_in) begin
    hs_q <= hsync_n_in;
    vs_q <= vsync_n_in;
    if (de_in) begin
      last_px_out <= data_in;
      px_cnt_out <= px_cnt_out + 1;
    end else if (data_in !== 24'h000000) begin
      blank_bad_out <= blank_bad_out + 1;
    end
    // a frame closes on the falling vertical sync; blanking has no data
    if (vs_q && !vsync_n_in) begin
      frame_px_out <= run_px;
      frame_lines_out <= run_lines;
      frames_out <= frames_out + 1;
      run_px <= 0;
      run_lines <= (hs_q && !hsync_n_in) ? 1 : 0;
    end else begin
      run_px <= run_px + (de_in ? 1 : 0);
      run_lines <= run_lines + ((hs_q && !hsync_n_in) ? 1 : 0);
    end
  end
endmodule // trpo_panel_model
`default_nettype wire

/* tft_rgb_panel_output_test.sv */
// self-checking bench for the tft rgb panel output block
`timescale 1ns/1ps
`default_nettype none
module tft_rgb_panel_output_test;
  import trpo_pkg::*;
  localparam logic [23:0] PIX = 24'h3c5a06;
  localparam logic [11:0] PAL6 = 12'h5a1;
  // only the active area is shrunk; blanking keeps its default lengths
  localparam logic [11:0] H_ACT = 12'h008;
  localparam logic [11:0] V_ACT = 12'h010;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pix_valid = 1'b0;
  logic [1:0] pix_fmt = 2'h0;
  logic [23:0] pix_data = 24'h000000;
  logic [1:0] width_sel = 2'h0;
  logic [7:0] div_lo = 8'h00;
  logic [7:0] div_hi = 8'h00;
  logic pal_wr = 1'b0;
  logic [8:0] pal_addr = 9'h000;
  logic [11:0] pal_wdata = 12'h000;
  logic pix_ready, pclk, hs_n, vs_n, de, underrun, n_pclk, n_hs, n_vs, n_de;
  logic [23:0] bus, n_bus, last_px, n_last;
  int px_cnt, blank_bad, frame_px, frame_lines, frames;
  int err_count = 0;
  int checks_done = 0;
  always #50 clk_in = ~clk_in;
  trpo_panel_output #(.H_ACTIVE(H_ACT), .V_ACTIVE(V_ACT)) uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pix_valid_in(pix_valid),
    .pix_fmt_in(pix_fmt), .pix_data_in(pix_data), .pix_ready_out(pix_ready),
    .width_sel_in(width_sel), .pclk_div_lo_in(div_lo), .pclk_div_hi_in(div_hi),
    .pal_wr_in(pal_wr), .pal_addr_in(pal_addr), .pal_wdata_in(pal_wdata), .pclk_out(pclk),
    .hsync_n_out(hs_n), .vsync_n_out(vs_n), .de_out(de), .panel_data_bus_out(bus),
    .underrun_out(underrun));
  // 18-line variant fed in lockstep with the full one
  trpo_panel_output #(.NARROW_BUS(1'b1), .H_ACTIVE(H_ACT), .V_ACTIVE(V_ACT)) uut_narrow (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pix_valid_in(pix_valid),
    .pix_fmt_in(pix_fmt), .pix_data_in(pix_data), .pix_ready_out(),
    .width_sel_in(width_sel), .pclk_div_lo_in(div_lo), .pclk_div_hi_in(div_hi),
    .pal_wr_in(pal_wr), .pal_addr_in(pal_addr), .pal_wdata_in(pal_wdata), .pclk_out(n_pclk),
    .hsync_n_out(n_hs), .vsync_n_out(n_vs), .de_out(n_de), .panel_data_bus_out(n_bus),
    .underrun_out());
  trpo_panel_model panel (.pclk_in(pclk), .hsync_n_in(hs_n), .vsync_n_in(vs_n),
    .de_in(de), .data_in(bus), .last_px_out(last_px), .px_cnt_out(px_cnt),
    .blank_bad_out(blank_bad), .frame_px_out(frame_px), .frame_lines_out(frame_lines),
    .frames_out(frames));
  trpo_panel_model panel_narrow (.pclk_in(n_pclk), .hsync_n_in(n_hs), .vsync_n_in(n_vs),
    .de_in(n_de), .data_in(n_bus), .last_px_out(n_last), .px_cnt_out(),
    .blank_bad_out(), .frame_px_out(), .frame_lines_out(), .frames_out());
  // =========================================================
  // reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic timed_out();
    err_count++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    end_sim();
  endtask
  // =========================================================
  // expected panel word from stored format and width code
  function automatic logic [23:0] exp_bus(input logic [1:0] w, input logic [1:0] f,
                                          input logic [23:0] d);
    logic [7:0] r, g, b;
    case (f)
      2'h0: {r, g, b} = d;
      2'h1: {r, g, b} = {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
      2'h2: {r, g, b} = {d[7:5], d[7:5], d[7:6], d[4:2], d[4:2], d[4:3], {4{d[1:0]}}};
      default: {r, g, b} = {{2{PAL6[11:8]}}, {2{PAL6[7:4]}}, {2{PAL6[3:0]}}};
    endcase
    case (w)
      2'h1: return {r[7:2], 2'h0, g[7:2], 2'h0, b[7:2], 2'h0};
      2'h2: return {r[7:3], 3'h0, g[7:2], 2'h0, b[7:3], 3'h0};
      default: return {r, g, b};
    endcase
  endfunction
  task automatic pal_write(input logic [8:0] a, input logic [11:0] v);
    @(negedge clk_in);
    pal_wr = 1'b1;
    pal_addr = a;
    pal_wdata = v;
    @(negedge clk_in);
    pal_wr = 1'b0;
  endtask
  task automatic wait_px(input int n);
    int start;
    start = px_cnt;
    // a whole frame of blanking may pass before the next active pixel
    for (int i = 0; i < 20000; i++) begin
      @(negedge clk_in);
      if (px_cnt >= start + n) return;
    end
    timed_out();
  endtask
  task automatic pclk_period(output int n);
    int rises;
    logic prev;
    rises = 0;
    n = 0;
    prev = pclk;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_in);
      if (rises > 0) n++;
      if (pclk && !prev) rises++;
      prev = pclk;
      if (rises == 2) return;
    end
    timed_out();
  endtask
  // =========================================================
  // scenarios
  task automatic t_reset();
    repeat (5) @(negedge clk_in);
    chk({pclk, hs_n, vs_n, de, underrun, pix_ready}, 32'h19);
    chk(bus, 24'h000000);
    sys_rst_in = 1'b0;
    $display("reset test done");
  endtask
  task automatic t_modes();
    pal_write(9'h00c, 12'hfff);
    pal_write(9'h00d, PAL6);
    pal_write(9'h00e, 12'h0f0);
    @(negedge clk_in);
    pix_valid = 1'b1;
    pix_data = PIX;
    // a format change must flush the buffered words; a width change
    // shows from the next launch on
    for (int f = 0; f < 4; f++) begin
      @(negedge clk_in);
      pix_fmt = 2'(f);
      wait_px(12);
      for (int w = 0; w < 4; w++) begin
        @(negedge clk_in);
        width_sel = 2'(w);
        wait_px(2);
        chk(last_px, exp_bus(2'(w), 2'(f), PIX));
        chk(n_last, exp_bus(2'(w), 2'(f), PIX) & 24'hfcfcfc);
      end
    end
    chk(blank_bad, 0);
    $display("width and format test done");
  endtask
  task automatic t_raster();
    int start;
    start = frames;
    // the first frame after reset closes early, so its line count is never checked
    for (int i = 0; i < 40000 && (frames < start + 1 || frames < 2); i++) @(negedge clk_in);
    if (frames < start + 1 || frames < 2) timed_out();
    chk(frame_px, int'(H_ACT) * int'(V_ACT));
    chk(frame_lines, int'(V_ACT) + int'(V_FP_DEF) + int'(V_SYNC_DEF) + int'(V_BP_DEF));
    chk(underrun, 1'b0);
    $display("raster test done");
  endtask
  task automatic t_clock();
    int n;
    @(negedge clk_in);
    div_lo = 8'h03;
    pclk_period(n);
    pclk_period(n);
    chk(n, 8);
    @(negedge clk_in);
    div_lo = 8'h00;
    div_hi = 8'h01;
    pclk_period(n);
    pclk_period(n);
    chk(n, 514);
    chk(pix_ready, 1'b0);
    @(negedge clk_in);
    pix_valid = 1'b0;
    div_hi = 8'h00;
    for (int i = 0; i < 20000 && !(underrun === 1'b1); i++) @(negedge clk_in);
    chk(underrun, 1'b1);
    chk(pix_ready, 1'b1);
    $display("clock and buffer test done");
  endtask
  initial begin
    t_reset();
    t_modes();
    t_raster();
    t_clock();
    end_sim();
  end
endmodule // tft_rgb_panel_output_test
`default_nettype wire
